/* File: fcss_host.sv */
`timescale 1ns/100ps
`default_nettype none
//Contract
// - Host toggles strobes for each poll
// - Program is setup then address/data write
// - Erase setup then confirm with block
// - Erase resume with confirm command
// - Lock setup then lock/unlock/down value
module fcss_host
    import fcss_pkg::*;
#(
    parameter int AW = 21,
    parameter int DW = 16
) (
    // Clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    // User request
    input  wire logic          i_req,
    input  wire logic [2:0]    i_op,
    input  wire logic [7:0]    i_cmd,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [DW-1:0] i_data,
    output logic               o_ready,
    // User answer
    output logic               o_done,
    output logic [DW-1:0]      o_rdata,
    output logic [7:0]         o_status,
    output logic               o_err,
    // Flash pins
    output logic               o_reset_powerdown_n,
    output logic               o_ce_n,
    output logic               o_oe_n,
    output logic               o_we_n,
    output logic [AW-1:0]      o_addr,
    output logic [DW-1:0]      o_dq_out,
    output logic               o_dq_oe,
    input  wire logic [DW-1:0] i_dq_in
);
    typedef enum logic [2:0] {
        FCSS_H_IDLE  = 3'b000,
        FCSS_H_CMD   = 3'b001,
        FCSS_H_DATA  = 3'b011,
        FCSS_H_POLL  = 3'b010,
        FCSS_H_READ  = 3'b110,
        FCSS_H_DONE  = 3'b111
    } fcss_h_t;

    typedef struct packed {
        fcss_h_t       st;
        logic [2:0]    op;
        logic [7:0]    cmd;
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
        logic [DW-1:0] rdata;
        logic [7:0]    status;
        logic          err;
        logic          done;
        logic          started;
        logic          rst_n;
    } fcss_hst_t;

    fcss_hst_t s_q, s_d;

    logic          cy_start;
    logic          cy_write;
    logic [AW-1:0] cy_addr;
    logic [DW-1:0] cy_data;
    logic          cy_busy;
    logic          cy_done;
    logic [DW-1:0] cy_rdata;
    logic [7:0]    sr;

    assign sr = cy_rdata[7:0];

    always_comb begin
        s_d       = s_q;
        s_d.done  = 1'b0;
        s_d.rst_n = 1'b1;
        cy_start  = 1'b0;
        cy_write  = 1'b1;
        cy_addr   = s_q.addr;
        cy_data   = {{(DW-8){1'b0}}, s_q.cmd};
        case (s_q.st)
            FCSS_H_IDLE: begin
                if (i_req) begin
                    s_d.op   = i_op;
                    s_d.cmd  = i_cmd;
                    s_d.addr = i_addr;
                    s_d.data = i_data;
                    s_d.started = 1'b0;
                    s_d.st   = (i_op == 3'(FCSS_OP_READ)) ? FCSS_H_READ :
                               (i_op == 3'(FCSS_OP_POLL)) ? FCSS_H_POLL : FCSS_H_CMD;
                end
            end
            FCSS_H_CMD: begin
                cy_start = !cy_busy && !s_q.started;
                if (cy_start) begin
                    s_d.started = 1'b1;
                end
                if (cy_done) begin
                    s_d.started = 1'b0;
                    s_d.st = (s_q.op == 3'(FCSS_OP_WRITE2)) ? FCSS_H_DATA : FCSS_H_DONE;
                end
            end
            FCSS_H_DATA: begin
                cy_data  = s_q.data;
                cy_start = !cy_busy && !s_q.started;
                if (cy_start) begin
                    s_d.started = 1'b1;
                end
                if (cy_done) begin
                    s_d.started = 1'b0;
                    // device now returns status, so poll
                    s_d.st = FCSS_H_POLL;
                end
            end
            FCSS_H_POLL: begin
                // one full strobe cycle per poll
                cy_write = 1'b0;
                cy_start = !cy_busy && !s_q.started;
                if (cy_start) begin
                    s_d.started = 1'b1;
                end
                if (cy_done) begin
                    s_d.started = 1'b0;
                    if (sr[FCSS_SR_READY]) begin
                        s_d.status = sr;
                        s_d.err = sr[FCSS_SR_LOCKED] || sr[FCSS_SR_SUPPLY] ||
                                  sr[FCSS_SR_PERR] || sr[FCSS_SR_EERR];
                        s_d.st = FCSS_H_DONE;
                    end
                end
            end
            FCSS_H_READ: begin
                cy_write = 1'b0;
                cy_start = !cy_busy && !s_q.started;
                if (cy_start) begin
                    s_d.started = 1'b1;
                end
                if (cy_done) begin
                    s_d.started = 1'b0;
                    s_d.rdata = cy_rdata;
                    s_d.st = FCSS_H_DONE;
                end
            end
            FCSS_H_DONE: begin
                s_d.done = 1'b1;
                s_d.st   = FCSS_H_IDLE;
            end
            default: s_d.st = FCSS_H_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    fcss_cycle #(
        .AW (AW),
        .DW (DW)
    ) u_cycle (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_start  (cy_start),
        .i_write  (cy_write),
        .i_addr   (cy_addr),
        .i_data   (cy_data),
        .o_busy   (cy_busy),
        .o_done   (cy_done),
        .o_rdata  (cy_rdata),
        .o_ce_n   (o_ce_n),
        .o_oe_n   (o_oe_n),
        .o_we_n   (o_we_n),
        .o_addr   (o_addr),
        .o_dq_out (o_dq_out),
        .o_dq_oe  (o_dq_oe),
        .i_dq_in  (i_dq_in)
    );

    // flash held in reset with the host
    assign o_reset_powerdown_n = s_q.rst_n;
    assign o_ready  = (s_q.st == FCSS_H_IDLE);
    assign o_done   = s_q.done;
    assign o_rdata  = s_q.rdata;
    assign o_status = s_q.status;
    assign o_err    = s_q.err;
endmodule : fcss_host
`default_nettype wire

/* File: fcss_pkg.sv */
package fcss_pkg;
    // Command codes
    localparam logic [7:0] FCSS_CMD_READ_ARRAY   = 8'hFF;
    localparam logic [7:0] FCSS_CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] FCSS_CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] FCSS_CMD_READ_QUERY   = 8'h98;
    localparam logic [7:0] FCSS_CMD_READ_CONFIG  = 8'h90;
    localparam logic [7:0] FCSS_CMD_PROG_SETUP   = 8'h40;
    localparam logic [7:0] FCSS_CMD_PROG_ALT     = 8'h10;
    localparam logic [7:0] FCSS_CMD_ERASE_SETUP  = 8'h20;
    localparam logic [7:0] FCSS_CMD_CONFIRM      = 8'hD0;
    localparam logic [7:0] FCSS_CMD_SUSPEND      = 8'hB0;
    localparam logic [7:0] FCSS_CMD_LOCK_SETUP   = 8'h60;
    localparam logic [7:0] FCSS_CMD_LOCK         = 8'h01;
    localparam logic [7:0] FCSS_CMD_LOCK_DOWN    = 8'h2F;
    localparam logic [7:0] FCSS_UPPER_ZERO       = 8'h00;
    // Status bit positions
    localparam int FCSS_SR_LOCKED  = 1;
    localparam int FCSS_SR_PSUSP   = 2;
    localparam int FCSS_SR_SUPPLY  = 3;
    localparam int FCSS_SR_PERR    = 4;
    localparam int FCSS_SR_EERR    = 5;
    localparam int FCSS_SR_ESUSP   = 6;
    localparam int FCSS_SR_READY   = 7;
    // Bus cycle timing, in ns, rounded up to clocks
    localparam int FCSS_T_SETUP_NS = 20;
    localparam int FCSS_T_PULSE_NS = 60;
    localparam int FCSS_CLK_NS     = 20;
    localparam logic [3:0] FCSS_SETUP_CYC =
        4'((FCSS_T_SETUP_NS + FCSS_CLK_NS - 1) / FCSS_CLK_NS);
    localparam logic [3:0] FCSS_PULSE_CYC =
        4'((FCSS_T_PULSE_NS + FCSS_CLK_NS - 1) / FCSS_CLK_NS);
    // User operations
    typedef enum logic [2:0] {
        FCSS_OP_WRITE1  = 3'h0,
        FCSS_OP_WRITE2  = 3'h1,
        FCSS_OP_READ    = 3'h2,
        FCSS_OP_POLL    = 3'h3
    } fcss_op_t;
endpackage : fcss_pkg

/* File: fcss_cycle.sv */
`timescale 1ns/100ps
`default_nettype none
// One bus cycle on the flash pins: setup, strobe pulse, release
module fcss_cycle
    import fcss_pkg::*;
#(
    parameter int AW = 21,
    parameter int DW = 16
) (
    // Clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    // Request
    input  wire logic          i_start,
    input  wire logic          i_write,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [DW-1:0] i_data,
    output logic               o_busy,
    output logic               o_done,
    output logic [DW-1:0]      o_rdata,
    // Flash pins
    output logic               o_ce_n,
    output logic               o_oe_n,
    output logic               o_we_n,
    output logic [AW-1:0]      o_addr,
    output logic [DW-1:0]      o_dq_out,
    output logic               o_dq_oe,
    input  wire logic [DW-1:0] i_dq_in
);
    typedef enum logic [1:0] {
        FCSS_CY_IDLE  = 2'b00,
        FCSS_CY_SETUP = 2'b01,
        FCSS_CY_PULSE = 2'b11,
        FCSS_CY_END   = 2'b10
    } fcss_cy_t;

    typedef struct packed {
        fcss_cy_t        st;
        logic [3:0]      cnt;
        logic            wr;
        logic [AW-1:0]   addr;
        logic [DW-1:0]   wdata;
        logic [DW-1:0]   rdata;
        logic            done;
    } fcss_cyst_t;

    fcss_cyst_t s_q, s_d;

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        case (s_q.st)
            FCSS_CY_IDLE: begin
                if (i_start) begin
                    s_d.st    = FCSS_CY_SETUP;
                    s_d.cnt   = FCSS_SETUP_CYC;
                    s_d.wr    = i_write;
                    s_d.addr  = i_addr;
                    s_d.wdata = i_data;
                end
            end
            FCSS_CY_SETUP: begin
                s_d.cnt = s_q.cnt - 4'h1;
                if (s_q.cnt == 4'h1) begin
                    s_d.st  = FCSS_CY_PULSE;
                    s_d.cnt = FCSS_PULSE_CYC;
                end
            end
            FCSS_CY_PULSE: begin
                s_d.cnt = s_q.cnt - 4'h1;
                if (s_q.cnt == 4'h1) begin
                    // Sample before the strobe rises
                    s_d.rdata = s_q.wr ? s_q.rdata : i_dq_in;
                    s_d.st    = FCSS_CY_END;
                end
            end
            FCSS_CY_END: begin
                // Strobes high one cycle, so every poll is a fresh edge
                s_d.st   = FCSS_CY_IDLE;
                s_d.done = 1'b1;
            end
            default: s_d.st = FCSS_CY_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_busy   = (s_q.st != FCSS_CY_IDLE);
    assign o_done   = s_q.done;
    assign o_rdata  = s_q.rdata;
    assign o_ce_n   = !(s_q.st == FCSS_CY_SETUP || s_q.st == FCSS_CY_PULSE);
    assign o_oe_n   = !(s_q.st == FCSS_CY_PULSE && !s_q.wr);
    assign o_we_n   = !(s_q.st == FCSS_CY_PULSE && s_q.wr);
    assign o_addr   = s_q.addr;
    assign o_dq_out = s_q.wdata;
    assign o_dq_oe  = s_q.wr && (s_q.st != FCSS_CY_IDLE);
endmodule : fcss_cycle
`default_nettype wire

/* File: fcss_host_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module fcss_host_chk (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_req,
    input wire logic       o_ready,
    input wire logic       o_done,
    input wire logic [7:0] o_status,
    input wire logic       o_err,
    input wire logic       o_ce_n,
    input wire logic       o_oe_n,
    input wire logic       o_we_n,
    input wire logic       o_dq_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_strobe_excl: assert property (!o_we_n |-> o_oe_n)
        else $error("read and write strobes overlap");
    a_poll_fresh: assert property ($fell(o_oe_n) |-> !$past(o_ce_n) && $past(o_ce_n, 2))
        else $error("status read without fresh chip select");
    a_read_len: assert property ($fell(o_oe_n) |-> !o_oe_n [*3] ##1 o_oe_n)
        else $error("read pulse length wrong");
    a_write_len: assert property ($fell(o_we_n) |-> !o_we_n [*3] ##1 (o_we_n && o_ce_n))
        else $error("write pulse length wrong");
    a_write_drive: assert property (!o_we_n |-> o_dq_oe && !o_ce_n)
        else $error("write without driven data");
    a_read_float: assert property (!o_oe_n |-> !o_dq_oe)
        else $error("host drives data during read");
    a_err_match: assert property (o_done |-> o_err == (|(o_status & 8'h3A)))
        else $error("error flag disagrees with status");
    a_req_start: assert property (i_req && o_ready |=> !o_ready ##[0:4] !o_ce_n)
        else $error("accepted request starts no cycle");
endmodule : fcss_host_chk
bind fcss_host fcss_host_chk chk_u (.*);
`default_nettype wire

/* File: fcss_flash_model.sv */
`timescale 1ns/100ps
`default_nettype none
module fcss_flash_model #(
    // Arbitrary query and configuration words
    parameter logic [15:0] QRY  = 16'h5A51,
    parameter logic [15:0] CFG  = 16'h00A7,
    parameter int          BUSY = 80
) (
    input  wire logic        i_clk,
    input  wire logic        i_rp_n,
    input  wire logic        i_ce_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic [20:0] i_addr,
    input  wire logic [15:0] i_dq,
    input  wire logic        i_vpp_bad,
    output logic      [15:0] o_dq
);
    logic [15:0] mem [16];
    logic [15:0] last;
    logic [7:0]  sr;
    logic [7:0]  sr_lat;
    logic [1:0]  md;
    logic [1:0]  pend;
    int          busy;
    logic        susp;
    logic        ers;
    logic [1:0]  eblk;
    wire         rd = !i_ce_n && !i_oe_n && i_we_n;
    wire         wr_act = !i_ce_n && !i_we_n;
    initial last = 16'h0000;
    initial foreach (mem[i]) mem[i] = 16'hFFFF;
    // Write ends when either strobe rises; both rise together here
    always @(negedge wr_act or negedge i_rp_n) begin
        if (!i_rp_n) begin
            sr = 8'h80;
            {md, pend, busy, susp, ers, eblk} = '0;
        end else if (pend != 0) begin
            md = 2'd1;
            if (pend == 2'd1 && susp && i_addr[3:2] == eblk) pend = 2'd0;
            if (pend == 2'd1 && i_vpp_bad) sr[3] = 1'b1;
            else if (pend == 2'd1) mem[i_addr[3:0]] &= i_dq;
            if (pend == 2'd1 && !susp) busy = i_vpp_bad ? 0 : BUSY;
            if (pend == 2'd1 && !susp) ers = 1'b0;
            if (pend == 2'd2 && i_dq[7:0] != 8'hD0) sr = sr | 8'h30;
            else if (pend == 2'd2 && i_vpp_bad) sr = sr | 8'h28;
            else if (pend == 2'd2) {ers, eblk, busy} = {1'b1, i_addr[3:2], BUSY};
            if (pend == 2'd2 && busy != 0)
                for (int i = 0; i < 4; i++) mem[{i_addr[3:2], 2'(i)}] = 16'hFFFF;
            sr[7] = susp || busy == 0;
            pend = 2'd0;
        end else if (busy != 0 && !susp) begin
            // only status and suspend while running
            if (i_dq[7:0] == 8'h70) md = 2'd1;
            susp = i_dq[7:0] == 8'hB0;
        end else if (!(susp && (i_dq[7:0] == 8'h50 || i_dq[7:0] == 8'h20 ||
                     (!ers && (i_dq[7:0] inside {8'h40, 8'h10, 8'h60}))))) begin
            case (i_dq[7:0])
                8'hFF: md = 2'd0;
                8'h70: md = 2'd1;
                8'h98: md = 2'd2;
                8'h90: md = 2'd3;
                8'h50: sr = sr & 8'hC5;
                8'h40, 8'h10: pend = 2'd1;
                8'h20: pend = 2'd2;
                8'h60: pend = 2'd3;
                // resume clears flags, back to status
                8'hD0: if (susp) {susp, sr, md} = {1'b0, sr & (ers ? 8'h3F : 8'h7B), 2'd1};
                default: md = md;
            endcase
        end
    end
    // ready low while running, both flags once halted
    always @(posedge i_clk) if (busy != 0) begin
        if (susp) sr = sr | (ers ? 8'hC0 : 8'h84);
        else busy--;
        sr[7] = susp || busy == 0;
    end
    // status frozen at the later strobe fall
    always @(negedge i_ce_n or negedge i_oe_n) if (!i_ce_n && !i_oe_n && i_we_n) sr_lat = sr;
    always @(posedge i_clk) if (rd) last <= o_dq;
    // released bus shows inverse of last value
    assign o_dq = !rd ? ~last : md == 2'd1 ? {8'h00, sr_lat} : md == 2'd2 ? QRY :
                  md == 2'd3 ? CFG : mem[i_addr[3:0]];
endmodule : fcss_flash_model
`default_nettype wire

/* File: flash_command_status_sequencer_test.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
$display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module flash_command_status_sequencer_test;
    import fcss_pkg::*;
    localparam logic [15:0] Q_W = 16'h5A51;
    localparam logic [15:0] C_W = 16'h00A7;
    logic        i_clk, i_rst, i_req, o_ready, o_done, o_err, o_reset_powerdown_n;
    logic        o_ce_n, o_oe_n, o_we_n, o_dq_oe, vpp_bad;
    logic [2:0]  i_op;
    logic [7:0]  i_cmd, o_status;
    logic [20:0] i_addr, o_addr;
    logic [15:0] i_data, o_rdata, o_dq_out, dev_dq, w;
    logic [15:0] mexp [4];
    logic [7:0]  modes [4] = '{8'h70, 8'h98, 8'h90, 8'hFF};
    logic [7:0]  lk [3] = '{8'h01, 8'hD0, 8'h2F};
    logic [17:0] exp_q [$];
    logic [31:0] seed = 32'h5419;
    int          miscompares = 0;
    int          samples_checked = 0;
    wire  [15:0] i_dq_in = o_dq_oe ? o_dq_out : dev_dq;
    fcss_host dut_u (.*);
    fcss_flash_model #(.QRY(Q_W), .CFG(C_W), .BUSY(80)) dev_u (.i_clk(i_clk),
        .i_rp_n(o_reset_powerdown_n), .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
        .i_addr(o_addr), .i_dq(i_dq_in), .i_vpp_bad(vpp_bad), .o_dq(dev_dq));
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s;
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xorshift
    task automatic close_out();
        $display("checked %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // Note the answer, issue at a falling edge, wait for done
    task automatic run(input logic [2:0] o, input logic [7:0] c, input logic [20:0] a,
                       input logic [15:0] d, input logic [1:0] k, input logic [15:0] e);
        int n;
        exp_q.push_back({k, e});
        {i_op, i_cmd, i_addr, i_data, i_req} = {o, c, a, d, 1'b1};
        @(negedge i_clk);
        i_req = 1'b0;
        for (n = 0; o_done !== 1'b1 && n < 400; n++) @(negedge i_clk);
        if (n == 400) miscompares++;
        @(negedge i_clk);
    endtask : run
    task automatic wr(input logic [7:0] c);
        run(3'h0, c, 21'h0, 16'h0, 2'd0, 16'h0);
    endtask : wr
    always @(negedge i_clk) if (o_done === 1'b1) begin
        logic [17:0] x;
        x = exp_q.pop_front();
        if (x[17:16] == 2'd1) `CHK(o_rdata, x[15:0])
        if (x[17:16] == 2'd2) `CHK(o_status, x[7:0])
        if (x[17:16] == 2'd2) `CHK(o_err, |(x[7:0] & 8'h3A))
    end
    initial begin
        {i_rst, i_req, vpp_bad, i_op, i_cmd, i_addr, i_data} = {3'b100, 48'h0};
        repeat (20) @(negedge i_clk);
        i_rst = 1'b0;
        repeat (4) @(negedge i_clk);
        seed = xorshift(seed);
        w = seed[15:0];
        run(3'h1, 8'h40, 21'h3, w, 2'd2, 16'h0080);
        run(3'h1, 8'h10, 21'h3, 16'hF0F0, 2'd2, 16'h0080);
        run(3'h1, 8'h40, 21'h5, ~w, 2'd2, 16'h0080);
        mexp = '{16'h0080, Q_W, C_W, ~w};
        for (int i = 0; i < 4; i++) begin
            wr(modes[i]);
            run(3'h2, 8'h0, 21'h5, 16'h0, 2'd1, mexp[i]);
        end
        run(3'h2, 8'h0, 21'h3, 16'h0, 2'd1, w & 16'hF0F0);
        $display("program and read modes end");
        run(3'h1, 8'h20, 21'h1, 16'h00D0, 2'd2, 16'h0080);
        wr(8'hFF);
        run(3'h2, 8'h0, 21'h3, 16'h0, 2'd1, 16'hFFFF);
        run(3'h2, 8'h0, 21'h5, 16'h0, 2'd1, ~w);
        run(3'h1, 8'h20, 21'h0, 16'h0055, 2'd2, 16'h00B0);
        wr(8'h50);
        run(3'h3, 8'h0, 21'h0, 16'h0, 2'd2, 16'h0080);
        vpp_bad = 1'b1;
        run(3'h1, 8'h40, 21'h7, 16'h0, 2'd2, 16'h0088);
        run(3'h1, 8'h20, 21'h4, 16'h00D0, 2'd2, 16'h00A8);
        vpp_bad = 1'b0;
        run(3'h1, 8'h40, 21'h7, 16'h0, 2'd2, 16'h00A8);
        wr(8'h50);
        run(3'h3, 8'h0, 21'h0, 16'h0, 2'd2, 16'h0080);
        $display("erase and faults end");
        wr(8'h40);
        run(3'h0, 8'h0F, 21'h9, 16'h0, 2'd0, 16'h0);
        wr(8'hFF);
        run(3'h2, 8'h0, 21'h9, 16'h0, 2'd1, 16'h0000);
        wr(8'hB0);
        run(3'h3, 8'h0, 21'h0, 16'h0, 2'd2, 16'h0084);
        wr(8'h60);
        wr(8'hD0);
        run(3'h2, 8'h0, 21'h9, 16'h0, 2'd1, 16'h0000);
        run(3'h3, 8'h0, 21'h0, 16'h0, 2'd2, 16'h0080);
        for (int i = 0; i < 3; i++) run(3'h1, 8'h60, 21'h8, {8'h00, lk[i]}, 2'd2, 16'h0080);
        wr(8'h20);
        run(3'h0, 8'hD0, 21'h4, 16'h0, 2'd0, 16'h0);
        wr(8'hB0);
        run(3'h3, 8'h0, 21'h0, 16'h0, 2'd2, 16'h00C0);
        wr(8'h20);
        run(3'h1, 8'h40, 21'h1, 16'h00FF, 2'd2, 16'h00C0);
        run(3'h1, 8'h40, 21'h5, 16'h0000, 2'd2, 16'h00C0);
        wr(8'hFF);
        run(3'h2, 8'h0, 21'h1, 16'h0, 2'd1, 16'h00FF);
        wr(8'hD0);
        run(3'h3, 8'h0, 21'h0, 16'h0, 2'd2, 16'h0080);
        wr(8'hFF);
        run(3'h2, 8'h0, 21'h5, 16'h0, 2'd1, 16'hFFFF);
        $display("suspend and lock end");
        vpp_bad = 1'b1;
        run(3'h1, 8'h40, 21'h2, 16'h0, 2'd2, 16'h0088);
        vpp_bad = 1'b0;
        i_rst = 1'b1;
        repeat (3) @(negedge i_clk);
        i_rst = 1'b0;
        repeat (4) @(negedge i_clk);
        wr(8'h70);
        run(3'h2, 8'h0, 21'h2, 16'h0, 2'd1, 16'h0080);
        $display("reset end");
        close_out();
    end
    initial begin
        #400000;
        miscompares++;
        close_out();
    end
endmodule : flash_command_status_sequencer_test
`default_nettype wire
